// File: core/umc_monitor_config.sv
// Contract
// [RL1] Filter holds 8-bit group, 16-bit partition.
// [RL2] Both matches: partition and group must equal.
// [RL3] No matching: measure all allocated storage.
// [RL4] Partition only: measure matching partition.
// [RL5] Group-only case is implementation choice.
// [RL6] Separate Secure and Non-secure filter copies.
// [RL7] Accesses address instance chosen by select register.
// [RL8] Filter at 0x810, control at 0x818.
// [RL9] Absent monitor types read zero, ignore writes.
// [RL10] Bit 31 enables bandwidth collection.
// [RL11] Selector: none, external 1-6, software trigger.
// [RL12] Capture copies normal and long counts.
// [RL13] Unimplemented capture sources never capture.
// [RL14] No capture support: selector, clear read zero.
// [RL15] Bit 27 clears counts after capture.
// [RL16] Overflow flag sticky until software writes zero.
// [RL17] No overflow possible: flag, irq enable zero.
// [RL18] Long counter has own flag and enable.
// [RL19] Bit 25 enables overflow interrupt.
// [RL20] Freeze clear: count wraps on overflow.
// [RL21] Freeze set: count stops on overflow.
// [RL22] Bandwidth control low byte reads 0x42.
// [RL23] Bit 17 group match, bit 16 partition match.
// [RL24] Group-only: behave as partition matching enabled.
// [RL25] Reserved bits read zero, ignore writes.
//
// Purpose: Configuration registers for storage and bandwidth usage monitors.
// Assumes: Single-cycle register port; answer on the clock after the request.
// Notes: Register reads answer one cycle after the request.
`timescale 1ns/1ps
`default_nettype none
module umc_monitor_config #(
  parameter int MONITORS = 4,
  parameter int RESOURCES = 1,
  parameter bit HAS_RIS = 1'b0,
  parameter bit HAS_STORAGE = 1'b1,
  parameter bit HAS_BANDWIDTH = 1'b1,
  parameter bit HAS_CAPTURE = 1'b1,
  parameter bit HAS_OVERFLOW = 1'b1,
  parameter bit HAS_OVERFLOW_IRQ = 1'b1,
  parameter bit HAS_LONG = 1'b1,
  parameter logic [6:1] EXT_CAPTURE_PRESENT = 6'h01,
  parameter int COUNT_WIDTH = 32,
  parameter int LONG_WIDTH = 44
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Register port
  input wire umc_pkg::umc_req_s req,
  output logic [31:0] rdata,
  output logic rvalid,
  // Storage labels to classify
  input wire umc_pkg::umc_label_s line_label,
  output logic line_counts,
  // Bandwidth traffic for the selected instance
  input wire logic [15:0] bw_increment,
  input wire logic bw_secure,
  // External capture events 1 to 6
  input wire logic [6:1] ext_capture,
  // Results
  output logic [COUNT_WIDTH-1:0] bw_capture_value,
  output logic [LONG_WIDTH-1:0] long_capture_value,
  output logic overflow_irq
);
  localparam int SLOTS = MONITORS * RESOURCES;
  localparam int SW = (SLOTS > 1) ? $clog2(SLOTS) : 1;

  initial if (MONITORS < 1 || MONITORS > 256 || RESOURCES < 1 || RESOURCES > 16)
    $error("Unsupported monitor or resource count");

  typedef struct packed {
    umc_pkg::umc_cfg_s [1:0][SLOTS-1:0] cfg;
    logic [1:0][7:0] monitor_index;
    logic [1:0][3:0] ris_sel;
    logic [31:0] rdata;
    logic rvalid;
    logic [1:0] sw_trigger;
  } umc_state_s;

  umc_state_s st_reg, st_next;
  logic [COUNT_WIDTH-1:0] bw_count;
  logic [LONG_WIDTH-1:0] long_count;
  logic bw_ovf, long_ovf;
  logic [SW-1:0] sel_slot;
  logic [15:0] inc_gated;
  logic capture_now;
  umc_pkg::umc_cfg_s cur;
  umc_pkg::umc_cfg_s lab_cfg;

  // Slot index of the monitor picked by a frame's select register.
  function automatic logic [SW-1:0] slot_of(input logic [7:0] mon, input logic [3:0] resource_instance_select);
    logic [31:0] idx;
    idx = HAS_RIS ? ({28'h0, resource_instance_select} * MONITORS + {24'h0, mon}) : {24'h0, mon}; // [RL7]
    slot_of = idx[SW-1:0];
  endfunction

  // True when a capture selector code names a source that exists and fired.
  function automatic logic capture_fires(input logic [2:0] code, input logic [6:1] ext,
                                         input logic sw);
    capture_fires = 1'b0;
    if (code == umc_pkg::CAPSEL_SOFTWARE)
    begin
      capture_fires = sw; // [RL11]
    end
    else if (code != umc_pkg::CAPSEL_NONE)
    begin
      capture_fires = ext[code] && EXT_CAPTURE_PRESENT[code]; // [RL13]
    end
  endfunction

  // Storage label match, with group-only treated as partition-and-group.
  function automatic logic label_match(input umc_pkg::umc_cfg_s c,
                                       input umc_pkg::umc_label_s l);
    logic part_ok, grp_ok;
    part_ok = (l.partition_id == c.partition_id);
    grp_ok = (l.monitoring_group == c.monitoring_group); // [RL1]
    if (c.group_match_enable)
    begin
      label_match = part_ok && grp_ok; // [RL2] [RL5] [RL24]
    end
    else if (c.partition_match_enable)
    begin
      label_match = part_ok; // [RL4]
    end
    else
    begin
      label_match = 1'b1; // [RL3]
    end
  endfunction

  // The bandwidth counter follows the slot chosen in the Secure or Non-secure frame.
  assign sel_slot = slot_of(st_reg.monitor_index[bw_secure], st_reg.ris_sel[bw_secure]);
  assign cur = st_reg.cfg[bw_secure][sel_slot];
  assign inc_gated = (HAS_BANDWIDTH && cur.bw_enable) ? bw_increment : 16'h0000; // [RL10]
  assign capture_now = HAS_CAPTURE &&
                       capture_fires(cur.capture_selector, ext_capture,
                                     st_reg.sw_trigger[bw_secure]);

  umc_bw_counter #(
    .WIDTH(COUNT_WIDTH)
  ) u_count (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .enable(cur.bw_enable),
    .freeze(cur.freeze_on_overflow),
    .increment(inc_gated),
    .capture(capture_now),
    .clear_after(cur.clear_after_capture),
    .count(bw_count),
    .captured(bw_capture_value),
    .overflow_pulse(bw_ovf)
  );

  umc_bw_counter #(
    .WIDTH(LONG_WIDTH)
  ) u_long (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .enable(cur.bw_enable && HAS_LONG),
    .freeze(cur.freeze_on_overflow),
    .increment(inc_gated),
    .capture(capture_now && HAS_LONG), // [RL12]
    .clear_after(cur.clear_after_capture), // [RL15]
    .count(long_count),
    .captured(long_capture_value),
    .overflow_pulse(long_ovf)
  );

  // Storage classification uses the frame matching the line's security.
  assign lab_cfg = st_reg.cfg[line_label.secure][slot_of(st_reg.monitor_index[line_label.secure],
                                                 st_reg.ris_sel[line_label.secure])]; // [RL6]
  assign line_counts = HAS_STORAGE && line_label.valid && label_match(lab_cfg, line_label);

  always_comb
  begin
    logic s;
    logic [SW-1:0] slot;
    umc_pkg::umc_cfg_s c;
    s = req.secure;
    slot = slot_of(st_reg.monitor_index[s], st_reg.ris_sel[s]);
    c = st_reg.cfg[s][slot];
    st_next = st_reg;
    st_next.rvalid = req.valid && !req.write;
    st_next.sw_trigger = 2'b00;
    st_next.rdata = 32'h0000_0000; // [RL25]
    // Sticky overflow flags: hardware set wins over software clear.
    if (req.valid && req.write)
    begin
      case (req.addr)
        umc_pkg::STORAGE_FILTER_OFFSET:
        begin
          if (HAS_STORAGE) // [RL9]
          begin
            st_next.cfg[s][slot].monitoring_group = req.wdata[23:16]; // [RL1] [RL8]
            st_next.cfg[s][slot].partition_id = req.wdata[15:0];
          end
        end
        umc_pkg::STORAGE_CONTROL_OFFSET:
        begin
          if (HAS_STORAGE)
          begin
            st_next.cfg[s][slot].group_match_enable = req.wdata[umc_pkg::GROUP_MATCH_BIT]; // [RL23]
            st_next.cfg[s][slot].partition_match_enable =
              req.wdata[umc_pkg::PARTITION_MATCH_BIT];
          end
        end
        umc_pkg::BANDWIDTH_CONTROL_OFFSET:
        begin
          if (HAS_BANDWIDTH) // [RL9]
          begin
            st_next.cfg[s][slot].bw_enable = req.wdata[umc_pkg::ENABLE_BIT];
            st_next.cfg[s][slot].capture_selector =
              HAS_CAPTURE ? req.wdata[umc_pkg::CAPSEL_LSB +: 3] : 3'h0; // [RL14]
            st_next.cfg[s][slot].clear_after_capture =
              HAS_CAPTURE && req.wdata[umc_pkg::CLEAR_CAPTURE_BIT];
            st_next.cfg[s][slot].overflow_flag =
              HAS_OVERFLOW && req.wdata[umc_pkg::OVERFLOW_BIT]; // [RL16] [RL17]
            st_next.cfg[s][slot].overflow_irq_enable = HAS_OVERFLOW && HAS_OVERFLOW_IRQ &&
              req.wdata[umc_pkg::OVERFLOW_IRQ_BIT]; // [RL19]
            st_next.cfg[s][slot].freeze_on_overflow =
              HAS_OVERFLOW && req.wdata[umc_pkg::FREEZE_BIT];
            st_next.cfg[s][slot].long_overflow_flag =
              HAS_LONG && HAS_OVERFLOW && req.wdata[umc_pkg::LONG_OVERFLOW_BIT]; // [RL18]
            st_next.cfg[s][slot].long_overflow_irq_enable = HAS_LONG && HAS_OVERFLOW &&
              HAS_OVERFLOW_IRQ && req.wdata[umc_pkg::LONG_OVERFLOW_IRQ_BIT];
          end
        end
        umc_pkg::MONITOR_SELECT_OFFSET:
        begin
          st_next.monitor_index[s] = req.wdata[7:0];
          st_next.ris_sel[s] = HAS_RIS ? req.wdata[umc_pkg::RIS_LSB +: 4] : 4'h0;
        end
        umc_pkg::CAPTURE_TRIGGER_OFFSET:
        begin
          // Bit 0 fires the trigger; a Secure write with bit 1 reaches both frames.
          st_next.sw_trigger[s] = req.wdata[0];
          if (s && req.wdata[1])
          begin
            st_next.sw_trigger[0] = req.wdata[0];
          end
        end
        default:
        begin
        end
      endcase
    end
    if (bw_ovf && HAS_OVERFLOW)
    begin
      st_next.cfg[bw_secure][sel_slot].overflow_flag = 1'b1; // [RL16]
    end
    if (long_ovf && HAS_OVERFLOW && HAS_LONG)
    begin
      st_next.cfg[bw_secure][sel_slot].long_overflow_flag = 1'b1; // [RL18]
    end
    if (req.valid && !req.write)
    begin
      case (req.addr)
        umc_pkg::STORAGE_FILTER_OFFSET:
          st_next.rdata = HAS_STORAGE ? {8'h00, c.monitoring_group, c.partition_id} : 32'h0;
        umc_pkg::STORAGE_CONTROL_OFFSET:
          st_next.rdata = HAS_STORAGE ? {14'h0, c.group_match_enable, c.partition_match_enable,
                                         8'h00, umc_pkg::STORAGE_TYPE_CODE} : 32'h0;
        umc_pkg::BANDWIDTH_CONTROL_OFFSET:
          st_next.rdata = HAS_BANDWIDTH ? {c.bw_enable, c.capture_selector,
                                           c.clear_after_capture, c.overflow_flag,
                                           c.overflow_irq_enable, c.freeze_on_overflow,
                                           8'h00, c.long_overflow_flag,
                                           c.long_overflow_irq_enable, 6'h00,
                                           umc_pkg::BANDWIDTH_TYPE_CODE} : 32'h0; // [RL22]
        umc_pkg::MONITOR_SELECT_OFFSET:
          st_next.rdata = {4'h0, st_reg.ris_sel[s], 16'h0, st_reg.monitor_index[s]};
        default:
          st_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign rdata = st_reg.rdata;
  assign rvalid = st_reg.rvalid;
  // Interrupt is a level while any enabled flag of the active instance is set.
  assign overflow_irq = (cur.overflow_flag && cur.overflow_irq_enable) ||
                        (cur.long_overflow_flag && cur.long_overflow_irq_enable); // [RL19]
endmodule // umc_monitor_config
`default_nettype wire

// File: core/umc_pkg.sv
// Purpose: Shared constants and types for the usage monitor configuration block.
// Assumes: 32-bit register port, 25 MHz sys_clk.
// Notes: Offsets are byte addresses within one security frame.
package umc_pkg;
  localparam logic [11:0] STORAGE_FILTER_OFFSET = 12'h810;
  localparam logic [11:0] STORAGE_CONTROL_OFFSET = 12'h818;
  localparam logic [11:0] BANDWIDTH_CONTROL_OFFSET = 12'h828;
  localparam logic [11:0] MONITOR_SELECT_OFFSET = 12'h800;
  localparam logic [11:0] CAPTURE_TRIGGER_OFFSET = 12'h808;
  localparam int ENABLE_BIT = 31;
  localparam int CAPSEL_LSB = 28;
  localparam int CLEAR_CAPTURE_BIT = 27;
  localparam int OVERFLOW_BIT = 26;
  localparam int OVERFLOW_IRQ_BIT = 25;
  localparam int FREEZE_BIT = 24;
  localparam int GROUP_MATCH_BIT = 17;
  localparam int PARTITION_MATCH_BIT = 16;
  localparam int LONG_OVERFLOW_BIT = 15;
  localparam int LONG_OVERFLOW_IRQ_BIT = 14;
  localparam int GROUP_LSB = 16;
  localparam int RIS_LSB = 24;
  localparam logic [7:0] BANDWIDTH_TYPE_CODE = 8'h42;
  localparam logic [7:0] STORAGE_TYPE_CODE = 8'h43;
  localparam logic [2:0] CAPSEL_NONE = 3'h0;
  localparam logic [2:0] CAPSEL_SOFTWARE = 3'h7;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  // One monitor's configuration.
  typedef struct packed {
    logic [7:0] monitoring_group;
    logic [15:0] partition_id;
    logic group_match_enable;
    logic partition_match_enable;
    logic bw_enable;
    logic [2:0] capture_selector;
    logic clear_after_capture;
    logic overflow_flag;
    logic overflow_irq_enable;
    logic freeze_on_overflow;
    logic long_overflow_flag;
    logic long_overflow_irq_enable;
  } umc_cfg_s;

  // Register port request.
  typedef struct packed {
    logic valid;
    logic write;
    logic secure;
    logic [11:0] addr;
    logic [31:0] wdata;
  } umc_req_s;

  // Labels of one cache line presented for measurement.
  typedef struct packed {
    logic valid;
    logic secure;
    logic [15:0] partition_id;
    logic [7:0] monitoring_group;
  } umc_label_s;
endpackage

// File: core/umc_bw_counter.sv
// Purpose: One bandwidth count with wrap or freeze, capture and clear.
// Assumes: Increment arrives already filtered.
// Notes: Capture takes the value before the increment of the same cycle.
`timescale 1ns/1ps
`default_nettype none
module umc_bw_counter #(
  parameter int WIDTH = 32
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Control
  input wire logic enable,
  input wire logic freeze,
  input wire logic [15:0] increment,
  input wire logic capture,
  input wire logic clear_after,
  // Results
  output logic [WIDTH-1:0] count,
  output logic [WIDTH-1:0] captured,
  output logic overflow_pulse
);
  // A 16-bit count still works: the carry out of the sum is the overflow.
  initial if (WIDTH < 16) $error("WIDTH must be at least the increment width");

  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] captured;
    logic frozen;
    logic ovf;
  } umc_cnt_s;

  umc_cnt_s st_reg, st_next;
  logic [WIDTH:0] sum;

  always_comb
  begin
    st_next = st_reg;
    st_next.ovf = 1'b0;
    sum = {1'b0, st_reg.count} + {{(WIDTH - 15){1'b0}}, increment};
    if (capture)
    begin
      st_next.captured = st_reg.count; // [RL12]
    end
    if (capture && clear_after)
    begin
      st_next.count = '0; // [RL15]
      st_next.frozen = 1'b0;
    end
    else if (enable && !st_reg.frozen && increment != 16'h0000) // [RL10]
    begin
      st_next.count = sum[WIDTH-1:0]; // [RL20] Wraps; residual kept when frozen. [RL21]
      if (sum[WIDTH])
      begin
        st_next.ovf = 1'b1;
        st_next.frozen = freeze; // [RL21]
      end
    end
    if (!freeze)
    begin
      st_next.frozen = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign count = st_reg.count;
  assign captured = st_reg.captured;
  assign overflow_pulse = st_reg.ovf;
endmodule // umc_bw_counter
`default_nettype wire

// File: bench/umc_monitor_config_asserts.sv
// Purpose: Port-level assertions for the usage monitor configuration block.
// Assumes: Register reads answer one cycle after the request.
// Notes: Bound to every instance of the top module.
`timescale 1ns/1ps
`default_nettype none
module umc_monitor_config_chk #(
  parameter int COUNT_WIDTH = 32
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Register port
  input wire umc_pkg::umc_req_s req,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  // Monitor traffic and results
  input wire umc_pkg::umc_label_s line_label,
  input wire logic line_counts,
  input wire logic [15:0] bw_increment,
  input wire logic bw_secure,
  input wire logic [6:1] ext_capture,
  input wire logic [COUNT_WIDTH-1:0] bw_capture_value,
  input wire logic overflow_irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic rd_req;
  assign rd_req = req.valid && !req.write;
  read_answer_a: assert property (rd_req |=> rvalid)
    else $error("read request not answered");
  idle_quiet_a: assert property (!rd_req |=> !rvalid && rdata == 32'h0)
    else $error("read data without a read request");
  bw_type_a: assert property (rd_req && req.addr == umc_pkg::BANDWIDTH_CONTROL_OFFSET |=>
    rdata[7:0] == 8'h42 && rdata[23:16] == 8'h0 && rdata[13:8] == 6'h0)
    else $error("bandwidth control type or reserved bits wrong");
  filter_reserved_a: assert property (rd_req && req.addr == 12'h810 |=> rdata[31:24] == 8'h0)
    else $error("filter reserved byte not zero");
  storage_ctrl_a: assert property (rd_req && req.addr == 12'h818 |=>
    rdata[31:18] == 14'h0 && rdata[15:0] == 16'h0043)
    else $error("storage control fixed bits wrong");
  unmapped_a: assert property (rd_req && req.addr == 12'h900 |=> rdata == 32'h0)
    else $error("unmapped read not zero");
  capture_hold_a: assert property (ext_capture == 6'h00 && !req.valid && !$past(req.valid) &&
    !$past(req.valid, 2) |=> $stable(bw_capture_value))
    else $error("capture value changed without an event");
  irq_rise_a: assert property ($rose(overflow_irq) |-> $past(req.valid) ||
    $past(bw_increment) != 16'h0 || $past(bw_increment, 2) != 16'h0 || bw_secure != $past(bw_secure))
    else $error("interrupt rose without traffic or write");
  irq_fall_a: assert property ($fell(overflow_irq) |->
    $past(req.valid && req.write) || bw_secure != $past(bw_secure))
    else $error("overflow interrupt dropped without a write");
  invalid_label_a: assert property (!line_label.valid |-> !line_counts)
    else $error("invalid label counted");
  cover property (rd_req ##1 rvalid);
  cover property ($rose(overflow_irq));
  cover property (!$stable(bw_capture_value));
endmodule // umc_monitor_config_chk

bind umc_monitor_config umc_monitor_config_chk #(.COUNT_WIDTH(COUNT_WIDTH)) u_chk (
  .sys_clk(sys_clk), .resetn(resetn), .req(req), .rdata(rdata), .rvalid(rvalid),
  .line_label(line_label), .line_counts(line_counts), .bw_increment(bw_increment),
  .bw_secure(bw_secure), .ext_capture(ext_capture), .bw_capture_value(bw_capture_value),
  .overflow_irq(overflow_irq));
`default_nettype wire

// File: bench/test_usage_monitor_config.sv
// Purpose: Self-checking bench for the usage monitor configuration block.
// Assumes: Count shortened to 16 bits so that overflow comes within a few cycles.
// Notes: Inputs change on the falling edge; only the Non-secure bandwidth path is driven.
`timescale 1ns/1ps
`default_nettype none
module test_usage_monitor_config;
  localparam logic [11:0] FLT = umc_pkg::STORAGE_FILTER_OFFSET;
  localparam logic [11:0] SCT = umc_pkg::STORAGE_CONTROL_OFFSET;
  localparam logic [11:0] BCT = umc_pkg::BANDWIDTH_CONTROL_OFFSET;
  localparam logic [11:0] SEL = umc_pkg::MONITOR_SELECT_OFFSET;
  localparam logic [31:0] EN = 32'h8000_0000;
  localparam logic [31:0] CLR = 32'h0800_0000;
  localparam logic [31:0] OVF = 32'h0400_0000;
  localparam logic [31:0] IRQ = 32'h0200_0000;
  localparam logic [31:0] FRZ = 32'h0100_0000;
  localparam logic [31:0] SEL1 = 32'h1000_0000;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  umc_pkg::umc_req_s req = '0;
  umc_pkg::umc_label_s line_label = '0;
  logic [15:0] bw_increment = 16'h0;
  logic [6:1] ext_capture = 6'h00;
  logic [31:0] rdata;
  logic rvalid;
  logic line_counts;
  logic [15:0] bw_capture_value;
  logic [43:0] long_capture_value;
  logic overflow_irq;
  int n_fail = 0;
  int check_count = 0;
  // Expected counting per match mode, one bit per label; group-only acts as both.
  logic [3:0] want [4] = '{4'hf, 4'h3, 4'h1, 4'h1};

  umc_monitor_config #(.COUNT_WIDTH(16)) dut (
    .sys_clk(sys_clk), .resetn(resetn), .req(req), .rdata(rdata), .rvalid(rvalid),
    .line_label(line_label), .line_counts(line_counts), .bw_increment(bw_increment),
    .bw_secure(1'b0), .ext_capture(ext_capture), .bw_capture_value(bw_capture_value),
    .long_capture_value(long_capture_value), .overflow_irq(overflow_irq));

  always #20 sys_clk = ~sys_clk;

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic sec, input logic [11:0] addr, input logic [31:0] data);
    @(negedge sys_clk);
    req = '{1'b1, 1'b1, sec, addr, data};
    @(negedge sys_clk);
    req.valid = 1'b0;
  endtask

  task automatic rd(input logic sec, input logic [11:0] addr, input logic [31:0] exp);
    @(negedge sys_clk);
    req = '{1'b1, 1'b0, sec, addr, 32'h0};
    @(negedge sys_clk);
    req.valid = 1'b0;
    chk("rvalid", {31'h0, rvalid}, 32'h1);
    chk("rdata", rdata, exp);
  endtask

  task automatic incr(input logic [15:0] v, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(negedge sys_clk);
      bw_increment = v;
    end
    @(negedge sys_clk);
    bw_increment = 16'h0;
  endtask

  task automatic cap(input logic [6:1] pat, input logic [31:0] exp);
    @(negedge sys_clk);
    ext_capture = pat;
    @(negedge sys_clk);
    ext_capture = 6'h00;
    @(negedge sys_clk);
    chk("capture", 32'(bw_capture_value), exp);
  endtask

  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge sys_clk);
    n_fail++;
    report_and_stop();
  end

  initial
  begin
    repeat (3) @(negedge sys_clk);
    resetn = 1'b1;
    rd(0, FLT, 32'h0);
    rd(0, SCT, 32'h0000_0043);
    rd(1, BCT, 32'h0000_0042);
    rd(0, 12'h900, 32'h0);
    wr(0, FLT, 32'hffff_ffff);
    rd(0, FLT, 32'h00ff_ffff);
    wr(1, FLT, 32'h0012_abcd);
    rd(0, FLT, 32'h00ff_ffff);
    rd(1, FLT, 32'h0012_abcd);
    wr(0, SCT, 32'hffff_ffff);
    rd(0, SCT, 32'h0003_0043);
    wr(0, BCT, 32'hfbff_7fff);
    rd(0, BCT, 32'hfb00_4042);
    wr(0, SEL, 32'h1);
    wr(0, FLT, 32'h0005_5555);
    rd(0, FLT, 32'h0005_5555);
    wr(0, SEL, 32'h0);
    rd(0, FLT, 32'h00ff_ffff);
    wr(0, FLT, 32'h00a5_1234);
    for (int m = 0; m < 4; m++)
    begin
      wr(0, SCT, 32'(m) << 16);
      for (int k = 0; k < 4; k++)
      begin
        @(negedge sys_clk);
        line_label = '{1'b1, 1'b0, (k[1] ? 16'h0 : 16'h1234), (k[0] ? 8'h0 : 8'ha5)};
        #1 chk("line_counts", {31'h0, line_counts}, {31'h0, want[m][k]});
      end
    end
    line_label.valid = 1'b0;
    wr(0, BCT, EN | SEL1);
    incr(16'h10, 5);
    cap(6'h01, 32'h50);
    chk("long capture", long_capture_value[31:0], 32'h50);
    cap(6'h01, 32'h50);
    wr(0, BCT, EN | SEL1 | CLR);
    cap(6'h01, 32'h50);
    cap(6'h01, 32'h0);
    wr(0, BCT, SEL1 | CLR);
    incr(16'h10, 4);
    cap(6'h01, 32'h0);
    wr(0, BCT, EN);
    incr(16'h30, 1);
    for (int c = 0; c < 7; c++)
    begin
      if (c != 1)
      begin
        wr(0, BCT, EN | CLR | (32'(c) << 28));
        cap(6'h3f, 32'h0);
      end
    end
    wr(0, BCT, EN | CLR | 32'h7000_0000);
    wr(0, umc_pkg::CAPTURE_TRIGGER_OFFSET, 32'h1);
    repeat (2) @(negedge sys_clk);
    chk("software capture", 32'(bw_capture_value), 32'h30);
    wr(0, BCT, EN | IRQ | SEL1 | CLR);
    incr(16'hffff, 2);
    rd(0, BCT, EN | IRQ | SEL1 | CLR | OVF | 32'h42);
    chk("irq", {31'h0, overflow_irq}, 32'h1);
    cap(6'h01, 32'hfffe);
    wr(0, BCT, EN | IRQ | SEL1 | CLR | FRZ);
    rd(0, BCT, EN | IRQ | SEL1 | CLR | FRZ | 32'h42);
    chk("irq", {31'h0, overflow_irq}, 32'h0);
    incr(16'hffff, 1);
    incr(16'h1, 1);
    incr(16'h10, 1);
    cap(6'h01, 32'h0);
    chk("irq", {31'h0, overflow_irq}, 32'h1);
    report_and_stop();
  end
endmodule // test_usage_monitor_config
`default_nettype wire
